/* File: pkg/clk_gate_defs.svh */
// register offsets, field positions and reset values of the peripheral clock gate block
`ifndef CLK_GATE_DEFS_SVH
`define CLK_GATE_DEFS_SVH

`define GATE_NUM_WORDS      6
`define GATE_NUM_PERIPH     32
`define GATE_OFS_ANALOG     12'h000
`define GATE_OFS_COMPARATOR 12'h004
`define GATE_OFS_CAPCMP     12'h008
`define GATE_OFS_TIMERS     12'h00c
`define GATE_OFS_SERIAL     12'h010
`define GATE_OFS_MISC       12'h014
`define GATE_WORD_RESET     32'h0000_0000
`define GATE_MASK_ANALOG    32'h0010_1101
`define GATE_MASK_COMP      32'h0000_0007
`define GATE_MASK_CAPCMP    32'h001f_001f
`define GATE_MASK_TIMERS    32'h0000_001f
`define GATE_MASK_SERIAL    32'h0103_0303
`define GATE_MASK_MISC      32'h0001_0003
`define AXI_RESP_OKAY       2'b00
`define AXI_RESP_SLVERR     2'b10

`endif

/* File: pkg/clk_gate_pkg.sv */
// types shared by the peripheral clock gate block
package clk_gate_pkg;

  // one word of the register file and its decoded index
  typedef logic [31:0] gate_word_t;
  typedef logic [2:0]  word_idx_t;

  // access request from the bus slave towards the register file
  typedef struct packed {
    logic       wr;
    logic       rd;
    word_idx_t  idx;
    logic       hit;
    gate_word_t wdata;
    logic [3:0] wstrb;
  } reg_req_t;

  // bus slave handshake states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WRESP,
    ST_RRESP
  } bus_state_t;

endpackage

/* File: src/clk_gate_cell.sv */
// glitch-free clock gate for one peripheral, latch-based enable
`timescale 1ns/10ps
module clk_gate_cell (
  input  wire logic clk_i,        // clock to be gated
  input  wire logic gate_i,       // high stops the clock
  output logic      gated_clk_o   // clock toward the peripheral
);

  logic enable_latch;

  // enable is captured while the clock is low so no runt pulse escapes
  always_latch begin
    if (!clk_i) begin
      enable_latch <= !gate_i;
    end
  end

  assign gated_clk_o = clk_i & enable_latch;

endmodule

/* File: src/axil_slave.sv */
// axi4-lite slave front end that turns bus transfers into register requests
`timescale 1ns/10ps
`include "clk_gate_defs.svh"
module axil_slave
  import clk_gate_pkg::*;
(
  input  wire logic        ref_clk_i,     // system clock
  input  wire logic        reset_n_i,     // async reset, active low
  input  wire logic [11:0] s_awaddr_i,    // write address
  input  wire logic        s_awvalid_i,   // write address valid
  output logic             s_awready_o,   // write address ready
  input  wire logic [31:0] s_wdata_i,     // write data
  input  wire logic [3:0]  s_wstrb_i,     // write byte enables
  input  wire logic        s_wvalid_i,    // write data valid
  output logic             s_wready_o,    // write data ready
  output logic [1:0]       s_bresp_o,     // write response
  output logic             s_bvalid_o,    // write response valid
  input  wire logic        s_bready_i,    // write response ready
  input  wire logic [11:0] s_araddr_i,    // read address
  input  wire logic        s_arvalid_i,   // read address valid
  output logic             s_arready_o,   // read address ready
  output logic [31:0]      s_rdata_o,     // read data
  output logic [1:0]       s_rresp_o,     // read response
  output logic             s_rvalid_o,    // read data valid
  input  wire logic        s_rready_i,    // read data ready
  output reg_req_t         req_o,         // one-cycle request to the register file
  input  wire gate_word_t  rdata_i        // read value for the current index
);

  // hit check of a byte address: word aligned and inside the mapped words, used for both channels
  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a[1:0] == 2'b00) && (a[11:2] < 10'(`GATE_NUM_WORDS));
  endfunction

  bus_state_t state_q, state_d;
  logic       aw_have_q, aw_have_d;
  logic       w_have_q, w_have_d;
  logic [11:0] awaddr_q, awaddr_d;
  gate_word_t wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] resp_q, resp_d;
  gate_word_t rdata_q, rdata_d;
  reg_req_t   req_d;
  logic       awready_d, wready_d, arready_d, bvalid_d, rvalid_d;

  // next state: address and data may arrive in any order, read wins a tie
  always_comb begin
    state_d   = state_q;
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    wstrb_d   = wstrb_q;
    resp_d    = resp_q;
    rdata_d   = rdata_q;
    req_d     = '0;
    unique case (state_q)
      ST_IDLE: begin
        if (s_awvalid_i && !aw_have_q) begin
          aw_have_d = 1'b1;
          awaddr_d  = s_awaddr_i;
        end
        if (s_wvalid_i && !w_have_q) begin
          w_have_d = 1'b1;
          wdata_d  = s_wdata_i;
          wstrb_d  = s_wstrb_i;
        end
        if (s_arvalid_i) begin
          req_d.rd  = 1'b1;
          req_d.idx = s_araddr_i[4:2];
          req_d.hit = addr_hit(s_araddr_i);
          rdata_d   = addr_hit(s_araddr_i) ? rdata_i : '0;
          resp_d    = addr_hit(s_araddr_i) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
          state_d   = ST_RRESP;
        end else if (aw_have_q && w_have_q) begin
          req_d.wr    = addr_hit(awaddr_q);
          req_d.idx   = awaddr_q[4:2];
          req_d.hit   = addr_hit(awaddr_q);
          req_d.wdata = wdata_q;
          req_d.wstrb = wstrb_q;
          resp_d      = addr_hit(awaddr_q) ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
          aw_have_d   = 1'b0;
          w_have_d    = 1'b0;
          state_d     = ST_WRESP;
        end
      end
      ST_WRESP: begin
        if (s_bready_i) begin
          state_d = ST_IDLE;
        end
      end
      ST_RRESP: begin
        if (s_rready_i) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // handshake outputs follow the next state so they leave straight from flops
    awready_d = (state_d == ST_IDLE) && !aw_have_d;
    wready_d  = (state_d == ST_IDLE) && !w_have_d;
    arready_d = (state_d == ST_IDLE);
    bvalid_d  = (state_d == ST_WRESP);
    rvalid_d  = (state_d == ST_RRESP);
  end

  // register stage; the rdata mux in the parent is indexed combinationally
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q   <= ST_IDLE;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
      resp_q    <= `AXI_RESP_OKAY;
      rdata_q   <= '0;
      req_o     <= '0;
      s_awready_o <= 1'b1;
      s_wready_o  <= 1'b1;
      s_arready_o <= 1'b1;
      s_bvalid_o  <= 1'b0;
      s_rvalid_o  <= 1'b0;
    end else begin
      state_q   <= state_d;
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      wstrb_q   <= wstrb_d;
      resp_q    <= resp_d;
      rdata_q   <= rdata_d;
      req_o     <= req_d;
      s_awready_o <= awready_d;
      s_wready_o  <= wready_d;
      s_arready_o <= arready_d;
      s_bvalid_o  <= bvalid_d;
      s_rvalid_o  <= rvalid_d;
    end
  end

  // response payload comes straight from its registers
  assign s_bresp_o   = resp_q;
  assign s_rresp_o   = resp_q;
  assign s_rdata_o   = rdata_q;

endmodule

/* File: src/periph_clock_gate.sv */
// peripheral clock gate control: six gate words, per-peripheral clock gates and bus guards
// Operation
// - a set gate bit stops every clock to its peripheral.
// - while gated, writes to that peripheral's registers are ignored and reads are not valid.
// - writing one to a gate bit disables the peripheral.
// - clearing a gate bit enables the peripheral, and all gate bits reset to zero.
// - word 1 holds adc at 0, charge timer at 8, comparator reference at 12, voltage detect at 20.
// - word 2 holds comparators 1 to 3 at bits 0 to 2.
// - word 3 holds input captures 1 to 5 at bits 0 to 4.
// - word 3 holds output compares 1 to 5 at bits 16 to 20.
// - word 4 holds timers 1 to 5 at bits 0 to 4.
// - word 5 holds uarts at 0 and 1, spis at 8 and 9, i2cs at 16 and 17, usb at 24.
// - word 6 holds calendar at 0, reference clock output at 1, parallel port at 16.
`timescale 1ns/10ps
`include "clk_gate_defs.svh"
module periph_clock_gate
  import clk_gate_pkg::*;
(
  input  wire logic        ref_clk_i,      // system clock, 40 MHz
  input  wire logic        reset_n_i,      // async reset, active low
  input  wire logic [11:0] s_awaddr_i,     // write address
  input  wire logic        s_awvalid_i,    // write address valid
  output logic             s_awready_o,    // write address ready
  input  wire logic [31:0] s_wdata_i,      // write data
  input  wire logic [3:0]  s_wstrb_i,      // write byte enables
  input  wire logic        s_wvalid_i,     // write data valid
  output logic             s_wready_o,     // write data ready
  output logic [1:0]       s_bresp_o,      // write response
  output logic             s_bvalid_o,     // write response valid
  input  wire logic        s_bready_i,     // write response ready
  input  wire logic [11:0] s_araddr_i,     // read address
  input  wire logic        s_arvalid_i,    // read address valid
  output logic             s_arready_o,    // read address ready
  output logic [31:0]      s_rdata_o,      // read data
  output logic [1:0]       s_rresp_o,      // read response
  output logic             s_rvalid_o,     // read data valid
  input  wire logic        s_rready_i,     // read data ready
  input  wire logic [31:0] periph_wr_i,    // peripheral register write strobes
  input  wire logic [31:0] periph_rd_i,    // peripheral register read strobes
  input  wire logic [31:0] periph_rdata_i [32], // peripheral read data
  output logic [31:0]      periph_wr_o,    // guarded write strobes
  output logic [31:0]      periph_rdata_o [32], // guarded read data
  output logic [31:0]      periph_gated_o, // registered gate state per peripheral
  output logic [31:0]      periph_clk_o    // gated clock per peripheral
);

  // ****************************************************************
  // peripheral slot map
  // ****************************************************************

  // slot order: adc, charge timer, comp ref, voltage detect, comp1-3, capture1-5,
  // compare1-5, timer1-5, uart1-2, spi1-2, i2c1-2, usb, calendar, refclk out,
  // parallel port; each slot names its word and bit
  localparam int SLOT_WORD [32] = '{
    0, 0, 0, 0, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 2, 2, 2,
    3, 3, 3, 3, 3, 4, 4, 4, 4, 4, 4, 4, 5, 5, 5
  };
  localparam int SLOT_BIT [32] = '{
    0, 8, 12, 20, 0, 1, 2, 0, 1, 2, 3, 4, 16, 17, 18, 19, 20,
    0, 1, 2, 3, 4, 0, 1, 8, 9, 16, 17, 24, 0, 1, 16
  };

  // writable bits of each word; unlisted bits stay zero
  function automatic gate_word_t word_mask(input word_idx_t i);
    unique case (i)
      3'd0:    word_mask = `GATE_MASK_ANALOG;
      3'd1:    word_mask = `GATE_MASK_COMP;
      3'd2:    word_mask = `GATE_MASK_CAPCMP;
      3'd3:    word_mask = `GATE_MASK_TIMERS;
      3'd4:    word_mask = `GATE_MASK_SERIAL;
      3'd5:    word_mask = `GATE_MASK_MISC;
      default: word_mask = '0;
    endcase
  endfunction

  // ****************************************************************
  // bus slave
  // ****************************************************************

  reg_req_t   req;
  gate_word_t rd_word;
  gate_word_t gate_q [6];
  gate_word_t gate_d [6];

  axil_slave u_bus (
    .ref_clk_i   (ref_clk_i),
    .reset_n_i   (reset_n_i),
    .s_awaddr_i  (s_awaddr_i),
    .s_awvalid_i (s_awvalid_i),
    .s_awready_o (s_awready_o),
    .s_wdata_i   (s_wdata_i),
    .s_wstrb_i   (s_wstrb_i),
    .s_wvalid_i  (s_wvalid_i),
    .s_wready_o  (s_wready_o),
    .s_bresp_o   (s_bresp_o),
    .s_bvalid_o  (s_bvalid_o),
    .s_bready_i  (s_bready_i),
    .s_araddr_i  (s_araddr_i),
    .s_arvalid_i (s_arvalid_i),
    .s_arready_o (s_arready_o),
    .s_rdata_o   (s_rdata_o),
    .s_rresp_o   (s_rresp_o),
    .s_rvalid_o  (s_rvalid_o),
    .s_rready_i  (s_rready_i),
    .req_o       (req),
    .rdata_i     (rd_word)
  );

  // read mux follows the live read address; unmapped words read zero
  always_comb begin
    rd_word = '0;
    if (s_araddr_i[4:2] < 3'(`GATE_NUM_WORDS)) begin
      rd_word = gate_q[s_araddr_i[4:2]];
    end
  end

  // ****************************************************************
  // gate words
  // ****************************************************************

  // byte-lane write, masked to the documented gate positions
  always_comb begin
    for (int w = 0; w < `GATE_NUM_WORDS; w++) begin
      gate_d[w] = gate_q[w];
      if (req.wr && req.hit && (req.idx == 3'(w))) begin
        for (int b = 0; b < 4; b++) begin
          if (req.wstrb[b]) begin
            gate_d[w][b*8 +: 8] = req.wdata[b*8 +: 8];
          end
        end
        gate_d[w] = gate_d[w] & word_mask(3'(w));
      end
    end
  end

  // all peripherals come out of reset enabled
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int w = 0; w < 6; w++) begin
        gate_q[w] <= `GATE_WORD_RESET;
      end
    end else begin
      for (int w = 0; w < 6; w++) begin
        gate_q[w] <= gate_d[w];
      end
    end
  end

  // ****************************************************************
  // per-peripheral gating and guards
  // ****************************************************************

  logic [31:0] gated_now;
  logic [31:0] wr_d;
  logic [31:0] rdata_d [32];

  // clock gates see the registered gate bits; the software enable of each
  // peripheral is expected to be off already, this block cannot check it
  generate
    for (genvar p = 0; p < `GATE_NUM_PERIPH; p++) begin : g_slot
      assign gated_now[p] = gate_q[SLOT_WORD[p]][SLOT_BIT[p]];
      clk_gate_cell u_cg (
        .clk_i       (ref_clk_i),
        .gate_i      (gated_now[p]),
        .gated_clk_o (periph_clk_o[p])
      );
      assign wr_d[p]    = periph_wr_i[p] & !gated_now[p];
      assign rdata_d[p] = (periph_rd_i[p] && !gated_now[p]) ? periph_rdata_i[p] : '0;
    end
  endgenerate

  // guard outputs registered, one cycle behind the peripheral strobes
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      periph_wr_o    <= '0;
      periph_gated_o <= '0;
      for (int p = 0; p < 32; p++) begin
        periph_rdata_o[p] <= '0;
      end
    end else begin
      periph_wr_o    <= wr_d;
      periph_gated_o <= gated_now;
      for (int p = 0; p < 32; p++) begin
        periph_rdata_o[p] <= rdata_d[p];
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************

  sequence s_gate_write(int w, int bitpos);
    req.wr && req.hit && req.idx == 3'(w) && req.wstrb[bitpos/8] && req.wdata[bitpos];
  endsequence

  chk_adc_sets_gate: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    s_gate_write(0, 0) |=> gate_q[0][0])
    else $error("adc gate bit did not set");

  chk_clear_enables: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (req.wr && req.hit && req.idx == 3'd3 && req.wstrb[0] && !req.wdata[0]) |=> !gate_q[3][0])
    else $error("timer1 gate bit did not clear");

  chk_blocked_write: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    gated_now[17] |=> !periph_wr_o[17])
    else $error("write strobe passed a gated timer");

  chk_gated_read_zero: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    gated_now[0] |=> periph_rdata_o[0] == '0)
    else $error("gated adc read not zero");

  chk_open_write: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (periph_wr_i[5] && !gated_now[5]) |=> periph_wr_o[5])
    else $error("write strobe lost on an enabled comparator");

  chk_open_read: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (periph_rd_i[0] && !gated_now[0]) |=> periph_rdata_o[0] == $past(periph_rdata_i[0]))
    else $error("enabled adc read data not passed");

  // sampled at the falling edge, where a running gated clock is high
  chk_clock_stops: assert property (@(negedge ref_clk_i) disable iff (!reset_n_i)
    (gated_now[22]) [*2] |-> !periph_clk_o[22])
    else $error("uart1 clock still running while gated");

  chk_clock_runs: assert property (@(negedge ref_clk_i) disable iff (!reset_n_i)
    (!gated_now[22]) [*2] |-> periph_clk_o[22])
    else $error("uart1 clock stopped while enabled");

  chk_word1_mask: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (gate_q[0] & ~`GATE_MASK_ANALOG) == '0)
    else $error("word 1 holds an unlisted bit");

  chk_word2_mask: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (gate_q[1] & ~`GATE_MASK_COMP) == '0)
    else $error("word 2 holds an unlisted bit");

  chk_word3_compare: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    s_gate_write(2, 20) |=> gate_q[2][20] ##0 periph_gated_o[16] == $past(gated_now[16]))
    else $error("compare5 gate bit did not set");

  chk_word3_capture: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    s_gate_write(2, 4) |=> gate_q[2][4])
    else $error("capture5 gate bit did not set");

  chk_word4_timer5: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    s_gate_write(3, 4) |=> gate_q[3][4] ##1 periph_gated_o[21])
    else $error("timer5 gate did not reach the output");

  chk_word5_i2c2: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    s_gate_write(4, 17) |=> gate_q[4][17])
    else $error("i2c2 gate bit did not set");

  chk_word6_parport: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    s_gate_write(5, 16) |=> gate_q[5][16])
    else $error("parallel port gate bit did not set");

endmodule

/* File: verification/periph_model.sv */
// partner model: peripheral units fed by the gated clocks and guarded strobes
`timescale 1ns/10ps
module periph_model (
  input  wire logic [31:0] clk_i,        // gated clock per unit
  input  wire logic        reset_n_i,    // async reset, active low
  input  wire logic [31:0] wr_i,         // guarded write strobe per unit
  input  wire logic [31:0] gated_i,      // gate state per unit
  output logic [31:0]      rdata_o [32], // unit number and clock edge count
  output logic             viol_o        // a unit was gated while still on
);
  logic        on_q  [32];
  logic [23:0] cnt_q [32];
  // each unit counts its own clock; a write switches its enable off
  for (genvar p = 0; p < 32; p++) begin : g_unit
    always_ff @(posedge clk_i[p] or negedge reset_n_i) begin
      if (!reset_n_i) begin
        cnt_q[p] <= 24'h000000;
        on_q[p]  <= 1'b1;
      end else begin
        cnt_q[p] <= cnt_q[p] + 24'h000001;
        if (wr_i[p]) on_q[p] <= 1'b0;
      end
    end
    assign rdata_o[p] = {8'(p), cnt_q[p]};
  end
  // gating a unit that is still on is undefined, so flag it for the bench
  always_comb begin
    viol_o = 1'b0;
    for (int p = 0; p < 32; p++) viol_o = viol_o | (gated_i[p] & on_q[p]);
  end
endmodule

/* File: verification/periph_clock_gate_tb_top.sv */
// self-checking bench of the peripheral clock gate block
`timescale 1ns/10ps
`include "clk_gate_defs.svh"
module periph_clock_gate_tb_top
  import clk_gate_pkg::*;
;
  // ********
  // bench signals
  // ********
  logic ref_clk_i, reset_n_i, s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i;
  logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, model_viol;
  logic [11:0] s_awaddr_i, s_araddr_i;
  logic [31:0] s_wdata_i, s_rdata_o;
  logic [3:0]  s_wstrb_i;
  logic [1:0]  s_bresp_o, s_rresp_o;
  logic [31:0] periph_wr_i, periph_rd_i, periph_wr_o, periph_gated_o, periph_clk_o;
  logic [31:0] model_rdata [32];
  logic [31:0] periph_rdata_o [32];
  logic [31:0] mask [6];
  logic [31:0] mir [6];
  logic [1:0]  b_q [$];
  logic [33:0] r_q [$];
  logic [15:0] lfsr_q = 16'h7668;
  int error_cnt = 0;
  int tests_run = 0;
  // gate bit of each slot as word * 32 + bit
  localparam int pos_tab [32] = '{0, 8, 12, 20, 32, 33, 34, 64, 65, 66, 67, 68, 80, 81, 82,
    83, 84, 96, 97, 98, 99, 100, 128, 129, 136, 137, 144, 145, 152, 160, 161, 176};

  periph_clock_gate dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .s_awaddr_i(s_awaddr_i), .s_awvalid_i(s_awvalid_i), .s_awready_o(s_awready_o),
    .s_wdata_i(s_wdata_i), .s_wstrb_i(s_wstrb_i), .s_wvalid_i(s_wvalid_i),
    .s_wready_o(s_wready_o), .s_bresp_o(s_bresp_o), .s_bvalid_o(s_bvalid_o),
    .s_bready_i(s_bready_i), .s_araddr_i(s_araddr_i), .s_arvalid_i(s_arvalid_i),
    .s_arready_o(s_arready_o), .s_rdata_o(s_rdata_o), .s_rresp_o(s_rresp_o),
    .s_rvalid_o(s_rvalid_o), .s_rready_i(s_rready_i), .periph_wr_i(periph_wr_i),
    .periph_rd_i(periph_rd_i), .periph_rdata_i(model_rdata), .periph_wr_o(periph_wr_o),
    .periph_rdata_o(periph_rdata_o), .periph_gated_o(periph_gated_o),
    .periph_clk_o(periph_clk_o));

  periph_model partner (.clk_i(periph_clk_o), .reset_n_i(reset_n_i), .wr_i(periph_wr_o),
    .gated_i(periph_gated_o), .rdata_o(model_rdata), .viol_o(model_viol));

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic final_report();
    $display("counts: %0d compares, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [33:0] seen, input logic [33:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic timeout(input string what);
    error_cnt++;
    $display("[FAIL] %0t %s wait ran out", $time, what);
    final_report();
  endtask

  // bus write: hold each channel until taken, bready until bvalid
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] st,
                           input logic [1:0] resp);
    bit aw_ok = 1'b0;
    bit w_ok = 1'b0;
    bit b_ok = 1'b0;
    b_q.push_back(resp);
    @(posedge ref_clk_i);
    s_awaddr_i <= a;
    s_wdata_i <= d;
    s_wstrb_i <= st;
    s_awvalid_i <= 1'b1;
    s_wvalid_i <= 1'b1;
    s_bready_i <= 1'b1;
    for (int n = 0; n < 64 && !b_ok; n++) begin
      @(posedge ref_clk_i);
      if (!aw_ok && s_awready_o) begin
        aw_ok = 1'b1;
        s_awvalid_i <= 1'b0;
      end
      if (!w_ok && s_wready_o) begin
        w_ok = 1'b1;
        s_wvalid_i <= 1'b0;
      end
      if (s_bvalid_o) begin
        b_ok = 1'b1;
        s_bready_i <= 1'b0;
      end
    end
    if (!b_ok) timeout("write");
  endtask

  task automatic axi_read(input logic [11:0] a, input logic [33:0] exp);
    bit ar_ok = 1'b0;
    bit r_ok = 1'b0;
    r_q.push_back(exp);
    @(posedge ref_clk_i);
    s_araddr_i <= a;
    s_arvalid_i <= 1'b1;
    s_rready_i <= 1'b1;
    for (int n = 0; n < 64 && !r_ok; n++) begin
      @(posedge ref_clk_i);
      if (!ar_ok && s_arready_o) begin
        ar_ok = 1'b1;
        s_arvalid_i <= 1'b0;
      end
      if (s_rvalid_o) begin
        r_ok = 1'b1;
        s_rready_i <= 1'b0;
      end
    end
    if (!r_ok) timeout("read");
  endtask

  // one write and read strobe to a slot; guarded results show one edge later
  task automatic poke(input int s, input logic ew);
    logic [31:0] exp_rd;
    @(posedge ref_clk_i);
    periph_wr_i[s] <= 1'b1;
    periph_rd_i[s] <= 1'b1;
    @(posedge ref_clk_i);
    periph_wr_i[s] <= 1'b0;
    periph_rd_i[s] <= 1'b0;
    exp_rd = ew ? model_rdata[s] : 32'h0;
    @(posedge ref_clk_i);
    check(34'(periph_wr_o[s]), 34'(ew), "guarded strobe");
    check(34'(periph_rdata_o[s]), 34'(exp_rd), "guarded read");
  endtask

  // counted at falling edges so the gated edges have settled
  task automatic clk_runs(input int s, input logic run);
    logic [23:0] c0;
    @(negedge ref_clk_i);
    c0 = model_rdata[s][23:0];
    repeat (4) @(negedge ref_clk_i);
    check(34'(model_rdata[s][23:0] - c0), run ? 34'h4 : 34'h0, "clock edges");
  endtask

  // response watcher: oldest note against each answer
  always @(posedge ref_clk_i) begin
    if (s_bvalid_o && s_bready_i)
      check(34'(s_bresp_o), (b_q.size() > 0) ? 34'(b_q.pop_front()) : 34'h3, "bresp");
    if (s_rvalid_o && s_rready_i)
      check({s_rresp_o, s_rdata_o}, (r_q.size() > 0) ? r_q.pop_front() : '1, "read");
  end

  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    #1000000;
    timeout("run");
  end

  initial begin
    logic [31:0] d;
    logic [3:0] st;
    int w;
    int b;
    {reset_n_i, s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i, s_rready_i} = '0;
    {s_awaddr_i, s_araddr_i, s_wdata_i, s_wstrb_i} = '0;
    periph_wr_i = '0;
    periph_rd_i = '0;
    for (int k = 0; k < 6; k++) mask[k] = 32'h0;
    for (int s = 0; s < 32; s++) mask[pos_tab[s] / 32][pos_tab[s] % 32] = 1'b1;
    repeat (5) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    check(34'(periph_gated_o), 34'h0, "gates after reset");
    for (int k = 0; k < 6; k++) axi_read(12'(k * 4), 34'h0);
    $display("test reset done");
    // each slot: switch it off, gate it, prove it frozen and guarded, then release
    for (int s = 0; s < 32; s++) begin
      w = pos_tab[s] / 32;
      b = pos_tab[s] % 32;
      poke(s, 1'b1);
      axi_write(12'(w * 4), 32'h1 << b, 4'hf, `AXI_RESP_OKAY);
      repeat (2) @(posedge ref_clk_i);
      check(34'(periph_gated_o), 34'h1 << s, "gate state");
      clk_runs(s, 1'b0);
      clk_runs((s + 1) % 32, 1'b1);
      poke(s, 1'b0);
      axi_read(12'(w * 4), {2'b00, 32'h1 << b});
      axi_write(12'(w * 4), 32'h0, 4'hf, `AXI_RESP_OKAY);
      repeat (2) @(posedge ref_clk_i);
      clk_runs(s, 1'b1);
      check(34'(model_viol), 34'h0, "gated while on");
    end
    $display("test slots done");
    for (int k = 0; k < 6; k++) begin
      axi_write(12'(k * 4), 32'hffff_ffff, 4'hf, `AXI_RESP_OKAY);
      axi_read(12'(k * 4), {2'b00, mask[k]});
      mir[k] = mask[k];
    end
    repeat (2) @(posedge ref_clk_i);
    check(34'(periph_gated_o[31:0]), 34'hffff_ffff, "all gated");
    axi_write(12'h018, 32'hffff_ffff, 4'hf, `AXI_RESP_SLVERR);
    axi_read(12'h018, {`AXI_RESP_SLVERR, 32'h0});
    axi_read(12'h002, {`AXI_RESP_SLVERR, 32'h0});
    $display("test masks done");
    // random byte-lane writes against a mirror of the six words
    for (int i = 0; i < 16; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      d[31:16] = lfsr_q;
      lfsr_q = lfsr_next(lfsr_q);
      d[15:0] = lfsr_q;
      w = int'(lfsr_q[2:0]) % 6;
      st = lfsr_q[7:4];
      for (int k = 0; k < 4; k++) if (st[k]) mir[w][8 * k +: 8] = d[8 * k +: 8];
      mir[w] = mir[w] & mask[w];
      axi_write(12'(w * 4), d, st, `AXI_RESP_OKAY);
      axi_read(12'(w * 4), {2'b00, mir[w]});
    end
    $display("test random done");
    repeat (4) @(posedge ref_clk_i);
    check(34'(b_q.size() + r_q.size()), 34'h0, "answers missing");
    final_report();
  end
endmodule
